/* File: design/ssq_cfg.svh */
// register offsets, field positions, reset values and counts of the step sequencer
// assumes a 32-bit plain register port with byte offsets
`ifndef SSQ_CFG_SVH
`define SSQ_CFG_SVH

`define SSQ_ADDR_W        8
`define SSQ_OFS_CTRL      8'h00
`define SSQ_OFS_CFG       8'h04
`define SSQ_OFS_COIL      8'h08
`define SSQ_OFS_READBACK  8'h0C

`define SSQ_CTRL_RES_LSB  0
`define SSQ_CTRL_RES_MSB  3
`define SSQ_CTRL_INTP_BIT 8
`define SSQ_CTRL_DEDG_BIT 9

`define SSQ_CFG_RBSEL_LSB 4
`define SSQ_CFG_RBSEL_MSB 5
`define SSQ_CFG_IFOFF_BIT 7

`define SSQ_COIL_A_LSB    0
`define SSQ_COIL_A_MSB    8
`define SSQ_COIL_B_LSB    9
`define SSQ_COIL_B_MSB    17

`define SSQ_RB_ANG_LSB    10
`define SSQ_RB_ANG_MSB    19
`define SSQ_RB_STILL_BIT  7
`define SSQ_RBSEL_ANGLE   2'h0

`define SSQ_RES_RESET     4'h0
`define SSQ_RES_FULL      4'h8
`define SSQ_PER_W         21
`define SSQ_IDLE_LIMIT    21'h100000
`define SSQ_USTEPS        5'h10
`define SSQ_QUARTER       10'h100
`define SSQ_SINE_PEAK     8'hF8
`define SSQ_HALF_PEAK     8'h7C

`endif

/* File: design/ssq_pkg.sv */
// types shared by the step sequencer and its testbench
// assumes nothing beyond a SystemVerilog compiler
package ssq_pkg;

  typedef struct packed {
    logic       neg;
    logic [7:0] mag;
  } ssq_coil_t;

  typedef struct packed {
    logic       double_edge_select;
    logic       interpolator_enable;
    logic [3:0] resolution_select;
  } ssq_ctrl_t;

  typedef struct packed {
    logic       step_interface_disable;
    logic [1:0] readback_select;
  } ssq_cfg_t;

endpackage

/* File: design/ssq_sine_rom.sv */
// quarter-wave sine table with two registered read ports
// assumes addresses are stable from the owning module on the same clock
`timescale 1ns/1ps

module ssq_sine_rom (
  input  wire logic       clk_in,
  input  wire logic [7:0] addr_a_in,
  input  wire logic [7:0] addr_b_in,
  output logic      [7:0] data_a_out,
  output logic      [7:0] data_b_out
);

  localparam logic [7:0] SINE_TAB [256] = '{
    8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h10, 8'h11,
    8'h13, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1B, 8'h1C, 8'h1E, 8'h1F, 8'h21, 8'h22, 8'h24,
    8'h25, 8'h27, 8'h28, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h30, 8'h31, 8'h33, 8'h34, 8'h36,
    8'h37, 8'h39, 8'h3A, 8'h3C, 8'h3D, 8'h3E, 8'h40, 8'h41, 8'h43, 8'h44, 8'h46, 8'h47,
    8'h49, 8'h4A, 8'h4C, 8'h4D, 8'h4F, 8'h50, 8'h51, 8'h53, 8'h54, 8'h56, 8'h57, 8'h59,
    8'h5A, 8'h5B, 8'h5D, 8'h5E, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h67, 8'h68, 8'h69,
    8'h6B, 8'h6C, 8'h6D, 8'h6F, 8'h70, 8'h72, 8'h73, 8'h74, 8'h76, 8'h77, 8'h78, 8'h7A,
    8'h7B, 8'h7C, 8'h7E, 8'h7F, 8'h80, 8'h81, 8'h83, 8'h84, 8'h85, 8'h87, 8'h88, 8'h89,
    8'h8A, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h91, 8'h92, 8'h93, 8'h94, 8'h96, 8'h97, 8'h98,
    8'h99, 8'h9A, 8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'hA0, 8'hA1, 8'hA3, 8'hA4, 8'hA5, 8'hA6,
    8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hB0, 8'hB1, 8'hB2, 8'hB3,
    8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF,
    8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9, 8'hC9, 8'hCA,
    8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF, 8'hCF, 8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD4,
    8'hD5, 8'hD6, 8'hD7, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDA, 8'hDB, 8'hDC, 8'hDC, 8'hDD,
    8'hDE, 8'hDF, 8'hDF, 8'hE0, 8'hE1, 8'hE1, 8'hE2, 8'hE2, 8'hE3, 8'hE4, 8'hE4, 8'hE5,
    8'hE5, 8'hE6, 8'hE7, 8'hE7, 8'hE8, 8'hE8, 8'hE9, 8'hE9, 8'hEA, 8'hEA, 8'hEB, 8'hEB,
    8'hEC, 8'hEC, 8'hED, 8'hED, 8'hEE, 8'hEE, 8'hEE, 8'hEF, 8'hEF, 8'hF0, 8'hF0, 8'hF0,
    8'hF1, 8'hF1, 8'hF1, 8'hF2, 8'hF2, 8'hF2, 8'hF3, 8'hF3, 8'hF3, 8'hF4, 8'hF4, 8'hF4,
    8'hF4, 8'hF5, 8'hF5, 8'hF5, 8'hF5, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF6, 8'hF7, 8'hF7,
    8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF7, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8, 8'hF8,
    8'hF8, 8'hF8, 8'hF8, 8'hF8
  };

  // registered read keeps the table mappable onto a block rom
  always_ff @(posedge clk_in) begin
    data_a_out <= SINE_TAB[addr_a_in];
    data_b_out <= SINE_TAB[addr_b_in];
  end

endmodule

/* File: design/ssq_sequencer.sv */
// step/direction microstep sequencer: synchroniser, edge select, angle counter,
// step interpolator, standstill detection and sine/cosine coil current lookup
// assumes step, direction and the standby strap are asynchronous pins and the
// register port is driven from logic on clk_in
`timescale 1ns/1ps
`include "ssq_cfg.svh"

module ssq_sequencer #(
  parameter logic [`SSQ_PER_W-1:0] IDLE_LIMIT = `SSQ_IDLE_LIMIT
) (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic                   step_in,
  input  wire logic                   dir_in,
  input  wire logic                   standby_half_in,
  input  wire logic [`SSQ_ADDR_W-1:0] addr_in,
  input  wire logic [31:0]            wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [31:0]            rdata_out,
  output ssq_pkg::ssq_coil_t          coil_a_out,
  output ssq_pkg::ssq_coil_t          coil_b_out,
  output logic      [9:0]             microstep_angle_out,
  output logic                        standstill_flag_out
);

  ssq_pkg::ssq_ctrl_t       ctrl_q;
  ssq_pkg::ssq_cfg_t        cfg_q;
  logic [17:0]              coil_set_q;
  logic [31:0]              rdata_q;
  logic [2:0]               sync1_q;
  logic [2:0]               sync2_q;
  logic                     step_prev_q;
  logic                     step_s;
  logic                     dir_s;
  logic                     half_s;
  logic                     rise;
  logic                     fall;
  logic                     act_edge;
  logic [`SSQ_PER_W-1:0]    per_q;
  logic                     standstill_q;
  logic [16:0]              ivl_q;
  logic [16:0]              ivl_d;
  logic [16:0]              tick_q;
  logic [4:0]               left_q;
  logic                     udir_q;
  logic                     ustep;
  logic [9:0]               angle_q;
  logic [3:0]               res_c;
  logic [9:0]               inc;
  logic [9:0]               ang_b;
  logic [7:0]               idx_a;
  logic [7:0]               idx_b;
  logic [7:0]               rom_a;
  logic [7:0]               rom_b;
  logic                     neg_a_q;
  logic                     neg_b_q;
  logic                     half_act;
  ssq_pkg::ssq_coil_t       coil_a_q;
  ssq_pkg::ssq_coil_t       coil_b_q;
  logic [31:0]              rb_word;

  // register writes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_q     <= '{double_edge_select: 1'b0, interpolator_enable: 1'b0,
                      resolution_select: `SSQ_RES_RESET};
      cfg_q      <= '0;
      coil_set_q <= '0;
    end else if (wr_in) begin
      case (addr_in)
        `SSQ_OFS_CTRL: begin
          ctrl_q.resolution_select   <= wdata_in[`SSQ_CTRL_RES_MSB:`SSQ_CTRL_RES_LSB];
          ctrl_q.interpolator_enable <= wdata_in[`SSQ_CTRL_INTP_BIT];
          ctrl_q.double_edge_select  <= wdata_in[`SSQ_CTRL_DEDG_BIT];
        end
        `SSQ_OFS_CFG: begin
          cfg_q.readback_select <= wdata_in[`SSQ_CFG_RBSEL_MSB:`SSQ_CFG_RBSEL_LSB];
          cfg_q.step_interface_disable <= wdata_in[`SSQ_CFG_IFOFF_BIT];
        end
        `SSQ_OFS_COIL: begin
          coil_set_q <= wdata_in[`SSQ_COIL_B_MSB:`SSQ_COIL_A_LSB];
        end
        default: begin
        end
      endcase
    end
  end

  // status word; other readback formats belong to blocks outside this one
  always_comb begin
    rb_word = '0;
    if (cfg_q.readback_select == `SSQ_RBSEL_ANGLE) begin
      rb_word[`SSQ_RB_ANG_MSB:`SSQ_RB_ANG_LSB] = angle_q;
    end
    rb_word[`SSQ_RB_STILL_BIT] = standstill_q;
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= '0;
    end else if (rd_in) begin
      case (addr_in)
        `SSQ_OFS_CTRL:     rdata_q <= {22'h000000, ctrl_q.double_edge_select,
                                       ctrl_q.interpolator_enable, 4'h0,
                                       ctrl_q.resolution_select};
        `SSQ_OFS_CFG:      rdata_q <= {24'h000000, cfg_q.step_interface_disable, 1'b0,
                                       cfg_q.readback_select, 4'h0};
        `SSQ_OFS_COIL:     rdata_q <= {14'h0000, coil_set_q};
        `SSQ_OFS_READBACK: rdata_q <= rb_word;
        default:           rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // pins are asynchronous; only the second stage is read by logic
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q     <= '0;
      sync2_q     <= '0;
      step_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {standby_half_in, dir_in, step_in};
      sync2_q     <= sync1_q;
      step_prev_q <= sync2_q[0];
    end
  end

  assign step_s = sync2_q[0];
  assign dir_s  = sync2_q[1];
  assign half_s = sync2_q[2];
  assign rise   = step_s & ~step_prev_q;
  assign fall   = ~step_s & step_prev_q;
  // disabled interface drops edges so the angle stays put and no burst starts; the idle counter still runs on to its limit
  assign act_edge = ~cfg_q.step_interface_disable &
                    (rise | (ctrl_q.double_edge_select & fall));

  // cycles since the last active edge, saturating at the idle limit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      per_q <= IDLE_LIMIT;
    end else if (act_edge) begin
      per_q <= `SSQ_PER_W'(1);
    end else if (per_q < IDLE_LIMIT) begin
      per_q <= per_q + `SSQ_PER_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standstill_q <= 1'b0;
    end else if (act_edge) begin
      standstill_q <= 1'b0;
    end else if (per_q >= IDLE_LIMIT) begin
      standstill_q <= 1'b1;
    end
  end

  // sixteenth of the interval that just ended; a saturated count gives IDLE_LIMIT/16, 2^16 at the default limit
  always_comb begin
    ivl_d = per_q[`SSQ_PER_W-1:4];
    if (ivl_d == 17'h00000) begin
      ivl_d = 17'h00001;
    end
  end

  // a disabled interface also stops a pending burst, so the angle stays frozen
  assign ustep = ctrl_q.interpolator_enable & ~act_edge &
                 ~cfg_q.step_interface_disable &
                 (left_q != 5'h00) & (tick_q == ivl_q - 17'h00001);

  // a new edge restarts the burst, so leftovers of a slow period are lost
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ivl_q  <= 17'h00001;
      tick_q <= '0;
      left_q <= '0;
      udir_q <= 1'b0;
    end else if (act_edge) begin
      ivl_q  <= ivl_d;
      tick_q <= '0;
      left_q <= ctrl_q.interpolator_enable ? `SSQ_USTEPS : 5'h00;
      udir_q <= dir_s;
    end else if (!ctrl_q.interpolator_enable || cfg_q.step_interface_disable) begin
      left_q <= '0;
      tick_q <= '0;
    end else if (ustep) begin
      tick_q <= '0;
      left_q <= left_q - 5'h01;
    end else if (left_q != 5'h00) begin
      tick_q <= tick_q + 17'h00001;
    end
  end

  // resolution codes above fullstep act as fullstep
  assign res_c = (ctrl_q.resolution_select > `SSQ_RES_FULL) ? `SSQ_RES_FULL
                                                             : ctrl_q.resolution_select;
  assign inc   = 10'h001 << res_c;

  // angle wraps naturally in 10 bits
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      angle_q <= '0;
    end else if (ustep) begin
      angle_q <= udir_q ? angle_q - 10'h001 : angle_q + 10'h001;
    end else if (act_edge && !ctrl_q.interpolator_enable) begin
      angle_q <= dir_s ? angle_q - inc : angle_q + inc;
    end
  end

  // cosine is the sine a quarter turn ahead; odd quadrants read mirrored
  assign ang_b = angle_q + `SSQ_QUARTER;
  assign idx_a = angle_q[8] ? ~angle_q[7:0] : angle_q[7:0];
  assign idx_b = ang_b[8] ? ~ang_b[7:0] : ang_b[7:0];

  ssq_sine_rom u_rom (
    .clk_in     (clk_in),
    .addr_a_in  (idx_a),
    .addr_b_in  (idx_b),
    .data_a_out (rom_a),
    .data_b_out (rom_b)
  );

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      neg_a_q <= 1'b0;
      neg_b_q <= 1'b0;
    end else begin
      neg_a_q <= angle_q[9];
      neg_b_q <= ang_b[9];
    end
  end

  assign half_act = half_s & standstill_q;

  // register-supplied currents bypass the table when the interface is off
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      coil_a_q <= '0;
      coil_b_q <= '0;
    end else if (cfg_q.step_interface_disable) begin
      coil_a_q <= coil_set_q[`SSQ_COIL_A_MSB:`SSQ_COIL_A_LSB];
      coil_b_q <= coil_set_q[`SSQ_COIL_B_MSB:`SSQ_COIL_B_LSB];
    end else begin
      coil_a_q.neg <= neg_a_q;
      coil_b_q.neg <= neg_b_q;
      coil_a_q.mag <= half_act ? {1'b0, rom_a[7:1]} : rom_a;
      coil_b_q.mag <= half_act ? {1'b0, rom_b[7:1]} : rom_b;
    end
  end

  assign rdata_out           = rdata_q;
  assign coil_a_out          = coil_a_q;
  assign coil_b_out          = coil_b_q;
  assign microstep_angle_out = angle_q;
  assign standstill_flag_out = standstill_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_single_edge_only: assert property (
    (act_edge && !ctrl_q.double_edge_select) |-> (step_s && !step_prev_q))
    else $error("falling step edge counted with double edge off");

  a_sync_two_stage: assert property (
    (act_edge && !ctrl_q.double_edge_select) |-> ($past(step_in, 2) && !$past(step_in, 3)))
    else $error("step edge not delayed by two stages");

  a_dir_step_size: assert property (
    (act_edge && !ctrl_q.interpolator_enable && !ustep)
    |=> (angle_q == ($past(dir_s) ? $past(angle_q) - $past(inc)
                                  : $past(angle_q) + $past(inc))))
    else $error("angle did not move by the step size");

  a_fullstep_grid: assert property (
    (act_edge && !ctrl_q.interpolator_enable && res_c == `SSQ_RES_FULL)
    |=> (angle_q[7:0] == $past(angle_q[7:0]) && angle_q[8] != $past(angle_q[8])))
    else $error("fullstep did not move a quarter turn");

  a_microstep_unit: assert property (
    ustep |=> (angle_q - $past(angle_q) == 10'h001 || $past(angle_q) - angle_q == 10'h001))
    else $error("microstep moved angle by other than one");

  a_burst_bound: assert property (
    (act_edge && ctrl_q.interpolator_enable) |=> (left_q == `SSQ_USTEPS))
    else $error("burst not restarted with sixteen microsteps");

  a_standstill_set: assert property (
    (per_q >= IDLE_LIMIT && !act_edge) |=> standstill_q)
    else $error("standstill not flagged after idle limit");

  a_standstill_clear: assert property (
    act_edge |=> (!standstill_q && per_q == `SSQ_PER_W'(1)))
    else $error("standstill not cleared by active edge");

  a_disable_freeze: assert property (
    cfg_q.step_interface_disable |=> $stable(angle_q))
    else $error("angle moved with step interface disabled");

  a_peak_limit: assert property (
    (coil_a_q.mag <= `SSQ_SINE_PEAK) || $past(cfg_q.step_interface_disable))
    else $error("table current above its peak");

  a_quarter_turn: assert property (
    ($past(angle_q, 2) == `SSQ_QUARTER && $past(angle_q) == `SSQ_QUARTER &&
     !$past(cfg_q.step_interface_disable) && !$past(half_act))
    |-> (coil_a_q.mag == `SSQ_SINE_PEAK && !coil_a_q.neg))
    else $error("coil A not at peak at a quarter turn");

  a_standby_half: assert property (
    ($past(half_act) && !$past(cfg_q.step_interface_disable))
    |-> (coil_a_q.mag <= `SSQ_HALF_PEAK && coil_b_q.mag <= `SSQ_HALF_PEAK))
    else $error("standby current not halved");

  c_fullstep_edge: cover property (act_edge && res_c == `SSQ_RES_FULL);
  c_interp_step:   cover property (ustep && left_q == 5'h01);
  c_standstill:    cover property (!standstill_q ##1 standstill_q);
  c_double_fall:   cover property (act_edge && fall);

endmodule

/* File: testbench/ssq_step_model.sv */
// behavioural motion controller that drives the step and direction pins
// assumes the bench raises go_in for one clock and waits for done_out
`timescale 1ns/1ps

module ssq_step_model (
  input  wire logic clk_in,
  input  wire logic go_in,
  input  wire logic dir_req_in,
  output logic      step_out,
  output logic      dir_out,
  output logic      done_out
);
  int unsigned cnt_q;

  initial begin
    step_out = 1'b0;
    dir_out  = 1'b0;
    done_out = 1'b0;
    cnt_q    = 0;
  end

  // direction settles four clocks ahead of the toggle, which then holds four clocks
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (go_in) begin
      dir_out <= dir_req_in;
      cnt_q   <= 8;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
      if (cnt_q == 5) step_out <= ~step_out; // equal spacing keeps a 50% duty
      if (cnt_q == 1) done_out <= 1'b1;
    end
  end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the step sequencer driven by a motion controller model
// assumes ssq_cfg.svh on the include path; idle limit shortened to 256 cycles
`timescale 1ns/1ps
`include "ssq_cfg.svh"

module tb_top;
  logic               clk_in, rstn_in, go, dreq, step, dir, done, standby, wr, rd, still, mon;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata, rv;
  logic [9:0]         ang, exp_ang, a0, lv;
  ssq_pkg::ssq_coil_t ca, cb;
  int                 n_mismatch, num_checks, cyc, nchg, c_first, c_last, t0;

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  ssq_sequencer #(.IDLE_LIMIT(21'h000100)) uut (
    .clk_in(clk_in), .rstn_in(rstn_in), .step_in(step), .dir_in(dir),
    .standby_half_in(standby), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .coil_a_out(ca), .coil_b_out(cb), .microstep_angle_out(ang),
    .standstill_flag_out(still));

  ssq_step_model ctl (.clk_in(clk_in), .go_in(go), .dir_req_in(dreq), .step_out(step),
                      .dir_out(dir), .done_out(done));

  // microstep timing monitor: counts angle changes while enabled
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (mon && ang !== lv) begin
      if (nchg == 0) c_first = cyc;
      c_last = cyc;
      nchg++;
      lv = ang;
    end
  end

  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic look(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask

  // one step pin toggle; returns once the controller reports it done
  task automatic tog(input logic d);
    int n;
    @(posedge clk_in);
    go   <= 1'b1;
    dreq <= d;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (done !== 1'b1 && n < 40);
    chk(32'(done), 32'h1);
  endtask

  function automatic logic [31:0] cval(input logic [1:0] k);
    return {23'h0, k[1], k[0] ? 8'hF8 : 8'h01};
  endfunction

  // the idle counter starts saturated, so standstill shows right after reset
  task automatic t_reset;
    chk(32'(ang), 32'h0);
    chk(32'(still), 32'h1);
    chk(32'(ca), 32'h001);
    chk(32'(cb), 32'h0F8);
    reg_rd(`SSQ_OFS_READBACK, rv);
    chk(rv, 32'h80);
    reg_rd(8'h10, rv);
    chk(rv, 32'h0);
  endtask

  task automatic t_steps;
    for (int r = 9; r >= 0; r--) begin
      reg_wr(`SSQ_OFS_CTRL, 32'(r));
      tog(1'b0);
      tog(1'b0);
      exp_ang = exp_ang + ((r > 8) ? 10'h100 : 10'(1 << r));
      chk(32'(ang), 32'(exp_ang));
    end
    reg_wr(`SSQ_OFS_CTRL, 32'h8);
    repeat (3) begin
      tog(1'b1);
      tog(1'b1);
    end
    exp_ang = exp_ang - 10'h300;
    chk(32'(ang), 32'(exp_ang));
    reg_rd(`SSQ_OFS_READBACK, rv);
    chk(32'(rv[19:10]), 32'(exp_ang));
    reg_wr(`SSQ_OFS_CTRL, 32'h200);
    tog(1'b0);
    tog(1'b0);
    exp_ang = exp_ang + 10'h2;
    chk(32'(ang), 32'(exp_ang));
  endtask

  task automatic t_coil;
    reg_wr(`SSQ_OFS_CTRL, 32'h0);
    tog(1'b1);
    tog(1'b1);
    reg_wr(`SSQ_OFS_CTRL, 32'h7);
    for (int k = 0; k < 4; k++) begin
      look(3);
      chk(32'(ca), cval(2'(k)));
      chk(32'(cb), cval(2'(k + 1)));
      repeat (2) begin
        tog(1'b0);
        tog(1'b0);
      end
    end
    chk(32'(ang), 32'h0);
  endtask

  task automatic t_standstill_flag;
    look(200);
    chk(32'(still), 32'h0);
    look(80);
    chk(32'(still), 32'h1);
    reg_rd(`SSQ_OFS_READBACK, rv);
    chk(32'(rv[7]), 32'h1);
    @(posedge clk_in);
    standby <= 1'b1;
    look(4);
    chk(32'(cb.mag), 32'h7C);
    @(posedge clk_in);
    standby <= 1'b0;
    tog(1'b0);
    chk(32'(still), 32'h0);
    tog(1'b0);
    chk(32'(ang), 32'h080);
  endtask

  task automatic t_disable;
    reg_wr(`SSQ_OFS_CFG, 32'h90);
    reg_wr(`SSQ_OFS_COIL, {14'h0, 9'h1AB, 9'h055});
    tog(1'b0);
    tog(1'b0);
    look(3);
    chk(32'(ang), 32'h080);
    chk(32'(ca), 32'h055);
    chk(32'(cb), 32'h1AB);
    reg_rd(`SSQ_OFS_READBACK, rv);
    chk(32'(rv[19:10]), 32'h0);
    reg_wr(`SSQ_OFS_CFG, 32'h0);
  endtask

  // double edge at equal spacing; the last gap is 48 cycles, so 3 cycles per microstep
  task automatic t_interp;
    reg_wr(`SSQ_OFS_CTRL, 32'h308);
    t0 = cyc + 4;
    for (int i = 0; i < 5; i++) begin
      while (cyc < t0 + 32 * i) @(negedge clk_in);
      tog(1'b0);
    end
    while (cyc < t0 + 176) @(negedge clk_in);
    a0   = ang;
    lv   = ang;
    nchg = 0;
    mon  = 1'b1;
    tog(1'b0);
    look(70);
    mon = 1'b0;
    chk(32'(nchg), 32'd16);
    chk(32'(c_last - c_first), 32'd45);
    chk(32'(ang - a0), 32'h10);
  endtask

  initial begin
    rstn_in    = 1'b0;
    go         = 1'b0;
    dreq       = 1'b0;
    standby    = 1'b0;
    wr         = 1'b0;
    rd         = 1'b0;
    addr       = 8'h00;
    wdata      = 32'h0;
    mon        = 1'b0;
    exp_ang    = 10'h000;
    n_mismatch = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    look(4);
    t_reset();
    t_steps();
    t_coil();
    t_standstill_flag();
    t_disable();
    t_interp();
    end_sim();
  end

  // the run needs about a thousand cycles; twenty times that means a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    end_sim();
  end
endmodule
